// File: logic/tws_defs.vh
// Purpose: Constants for the two-wire serial port.
// Assumes: Byte-wide register port, word addresses as printed.
// Notes: Included by logic/tws_port.v.
`ifndef TWS_DEFS_VH
`define TWS_DEFS_VH
`define TWS_ADDR_W 16
`define TWS_A_PCTRL0 16'h2d00
`define TWS_A_CFG 16'h2f01
`define TWS_A_DIVL 16'h2f02
`define TWS_A_DIVH 16'h2f03
`define TWS_A_DATA 16'h2f04
`define TWS_A_FLAGS 16'h2f05
`define TWS_A_IRQEN 16'h28a5
`define TWS_B_PORTEN 6
`define TWS_B_LSBF 4
`define TWS_B_NOSTART 3
`define TWS_B_NODATA 2
`define TWS_B_NOSTOP 1
`define TWS_B_NORESTART 0
`define TWS_B_ACK 0
`define TWS_B_BUSY 1
`define TWS_B_TXIE 4
`define TWS_B_ILIE 5
`define TWS_B_TXIF 2
`define TWS_B_ILIF 3
`define TWS_RST_BYTE 8'h00
`define TWS_CLK_MHZ 100
`define TWS_QUARTERS 4
`endif

// File: logic/tws_port.v
// Purpose: Master-only two-wire serial port with configurable frame parts.
// Assumes: One clock SYS_CLK, synchronous active-low reset RST_B.
// Notes: Each bit time is four quarter phases of TH+1 clocks each.
//
// Implementation choice: the plain strobed port.
`include "tws_defs.vh"
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Port enable hands pins to port
// - Port drives clock pin; software enables data input
// - START: data falls while clock high
// - Change data after fall, sample at rise; the code samples one quarter after the rise
// - Bit order follows order field
// - Ninth bit is acknowledge, low means acknowledged
// - STOP rises, RESTART falls, clock high
// - Clock falls first, then preset data level
// - Frame built only from selected parts
// - Zero bit means part performed
// - Invalid part combinations do nothing
// - START starts sixteen-bit clock counter
// - Clock is system clock over 4(TH+1)
// - Capture is wired-AND of bus
// - Captured byte and acknowledge readable
// - Data write when idle starts frame
// - Frame end clears busy flag
// - Frame done raises transmit interrupt
// - Writes while busy ignored, flag illegal; the code ignores and flags only CFG, DIVL, DIVH and DATA writes
// - Clock held low between frames; the code releases it high after a STOP
module tws_port #(
    parameter DIV_W = 16
) (
    // Clock and reset
    input wire SYS_CLK,
    input wire RST_B,
    // Register port
    input wire [`TWS_ADDR_W-1:0] ADDR,
    input wire [7:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [7:0] RDATA,
    // Interrupt request toward the core
    output wire IRQ,
    // Data wire pin
    input wire SDA_I,
    output wire SDA_O,
    output wire SDA_OE,
    // Clock wire pin
    input wire SCL_I,
    output wire SCL_O,
    output wire SCL_OE,
    // Pin mux status
    output wire PORT_ACTIVE
);
    localparam ST_IDLE = 3'd0;
    localparam ST_START = 3'd1;
    localparam ST_BITS = 3'd2;
    localparam ST_END = 3'd3;
    localparam ST_DONE = 3'd4;

    reg [7:0] pctrl_q;
    reg [7:0] cfg_q;
    reg [7:0] divl_q;
    reg [7:0] divh_q;
    reg [7:0] data_q;
    reg [7:0] irqen_q;
    reg ack_q;
    reg busy_q;
    reg txif_q;
    reg ilif_q;
    reg [2:0] st_q;
    reg [DIV_W-1:0] cnt_q;
    reg [1:0] ph_q;
    reg [3:0] bit_q;
    reg [7:0] sh_q;
    reg [7:0] rx_q;
    reg scl_q;
    reg sda_q;
    reg started_q;
    reg do_data_q;
    reg do_end_q;
    reg end_stop_q;
    reg sda_m1_q;
    reg sda_s_q;
    reg scl_m1_q;
    reg scl_s_q;

    wire port_en = pctrl_q[`TWS_B_PORTEN];
    wire [DIV_W-1:0] th = {divh_q, divl_q};
    wire tick = (cnt_q == th);
    wire lsbf = cfg_q[`TWS_B_LSBF];
    wire [3:0] parts = cfg_q[3:0];
    wire no_start = parts[`TWS_B_NOSTART];
    wire no_data = parts[`TWS_B_NODATA];
    wire no_end = parts[`TWS_B_NOSTOP] & parts[`TWS_B_NORESTART];
    wire stop_sel = ~parts[`TWS_B_NOSTOP];
    wire wr_cfgish = WR & (ADDR >= `TWS_A_CFG) & (ADDR <= `TWS_A_DATA);
    wire wr_ok = wr_cfgish & ~busy_q;
    wire wr_bad = wr_cfgish & busy_q;
    wire go = WR & (ADDR == `TWS_A_DATA) & ~busy_q;

    // Valid shapes: S+D, S, D+E, D, E (a zero selects a part); others are dropped
    function frame_valid;
        input ns, nd, ne;
        begin
            frame_valid = ~(ns & nd & ne) & ~(~ns & ~nd & ~ne) & ~(~ns & nd & ~ne);
        end
    endfunction

    // Bit k of the serial stream mapped onto the register
    function [2:0] bit_index;
        input lsb_first;
        input [3:0] k;
        begin
            bit_index = lsb_first ? k[2:0] : (3'd7 - k[2:0]);
        end
    endfunction

    assign PORT_ACTIVE = port_en;
    assign SCL_OE = port_en;
    assign SCL_O = scl_q;
    // Open-drain data: only a low is driven, a high is released to the pull-up
    assign SDA_OE = port_en & ~sda_q;
    assign SDA_O = 1'b0;
    assign IRQ = (txif_q & irqen_q[`TWS_B_TXIE]) | (ilif_q & irqen_q[`TWS_B_ILIE]);

    // Pin synchronisers
    always @(posedge SYS_CLK) begin
        if (!RST_B) begin
            sda_m1_q <= 1'b1;
            sda_s_q <= 1'b1;
            scl_m1_q <= 1'b1;
            scl_s_q <= 1'b1;
        end else begin
            sda_m1_q <= SDA_I;
            sda_s_q <= sda_m1_q;
            scl_m1_q <= SCL_I;
            scl_s_q <= scl_m1_q;
        end
    end

    // Register port
    always @(posedge SYS_CLK) begin
        if (!RST_B) begin
            pctrl_q <= `TWS_RST_BYTE;
            cfg_q <= `TWS_RST_BYTE;
            divl_q <= `TWS_RST_BYTE;
            divh_q <= `TWS_RST_BYTE;
            irqen_q <= `TWS_RST_BYTE;
            RDATA <= 8'h00;
        end else begin
            if (WR && ADDR == `TWS_A_PCTRL0) begin
                pctrl_q <= WDATA;
            end
            if (WR && ADDR == `TWS_A_IRQEN) begin
                irqen_q <= WDATA;
            end
            if (wr_ok && ADDR == `TWS_A_CFG) begin
                cfg_q <= WDATA;
            end
            if (wr_ok && ADDR == `TWS_A_DIVL) begin
                divl_q <= WDATA;
            end
            if (wr_ok && ADDR == `TWS_A_DIVH) begin
                divh_q <= WDATA;
            end
            RDATA <= 8'h00;
            if (RD) begin
                case (ADDR)
                    `TWS_A_PCTRL0: RDATA <= pctrl_q;
                    `TWS_A_CFG: RDATA <= cfg_q;
                    `TWS_A_DIVL: RDATA <= divl_q;
                    `TWS_A_DIVH: RDATA <= divh_q;
                    `TWS_A_DATA: RDATA <= data_q;
                    `TWS_A_FLAGS: RDATA <= {4'h0, ilif_q, txif_q, busy_q, ack_q};
                    `TWS_A_IRQEN: RDATA <= irqen_q;
                    default: RDATA <= 8'h00;
                endcase
            end
        end
    end

    // Frame engine; a bit time is four quarters: low-change, low, high-sample, high
    always @(posedge SYS_CLK) begin
        if (!RST_B) begin
            st_q <= ST_IDLE;
            cnt_q <= {DIV_W{1'b0}};
            ph_q <= 2'd0;
            bit_q <= 4'd0;
            sh_q <= 8'h00;
            rx_q <= 8'h00;
            data_q <= 8'h00;
            ack_q <= 1'b1;
            busy_q <= 1'b0;
            txif_q <= 1'b0;
            ilif_q <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            started_q <= 1'b0;
            do_data_q <= 1'b0;
            do_end_q <= 1'b0;
            end_stop_q <= 1'b0;
        end else begin
            // Software clears a flag by writing one; a new event wins over the clear
            if (WR && ADDR == `TWS_A_FLAGS) begin
                if (WDATA[`TWS_B_TXIF]) begin
                    txif_q <= 1'b0;
                end
                if (WDATA[`TWS_B_ILIF]) begin
                    ilif_q <= 1'b0;
                end
                if (WDATA[`TWS_B_ACK]) begin
                    ack_q <= 1'b1;
                end
            end
            if (wr_bad) begin
                ilif_q <= 1'b1;
            end
            if (go && ADDR == `TWS_A_DATA) begin
                data_q <= WDATA;
            end
            case (st_q)
                ST_IDLE: begin
                    cnt_q <= {DIV_W{1'b0}};
                    ph_q <= 2'd0;
                    if (go && port_en && frame_valid(no_start, no_data, no_end)) begin
                        busy_q <= 1'b1;
                        sh_q <= WDATA;
                        do_data_q <= ~no_data;
                        do_end_q <= ~no_end;
                        end_stop_q <= stop_sel;
                        bit_q <= 4'd0;
                        if (!no_start) begin
                            st_q <= ST_START;
                            scl_q <= 1'b1;
                            sda_q <= 1'b1;
                        end else begin
                            st_q <= no_data ? ST_END : ST_BITS;
                        end
                    end
                end
                ST_DONE: begin
                    st_q <= ST_IDLE;
                end
                default: begin
                    if (tick) begin
                        cnt_q <= {DIV_W{1'b0}};
                        ph_q <= ph_q + 2'd1;
                    end else begin
                        cnt_q <= cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
                    end
                end
            endcase
            if (tick && st_q == ST_START) begin
                // SCL stays high, SDA falls at the second quarter, SCL falls at the end
                if (ph_q == 2'd1) begin
                    sda_q <= 1'b0;
                end
                if (ph_q == 2'd3) begin
                    scl_q <= 1'b0;
                    started_q <= 1'b1;
                    st_q <= do_data_q ? ST_BITS : ST_DONE;
                end
            end
            if (tick && st_q == ST_BITS) begin
                case (ph_q)
                    2'd0: begin
                        scl_q <= 1'b0;
                        // Data bits from the byte, the ninth released for the receiver
                        sda_q <= (bit_q == 4'd8) ? 1'b1 : sh_q[bit_index(lsbf, bit_q)];
                    end
                    2'd1: scl_q <= 1'b1;
                    2'd2: begin
                        if (bit_q == 4'd8) begin
                            ack_q <= sda_s_q;
                        end else begin
                            rx_q[bit_index(lsbf, bit_q)] <= sda_s_q;
                        end
                    end
                    default: begin
                        scl_q <= 1'b0;
                        if (bit_q == 4'd8) begin
                            data_q <= rx_q;
                            st_q <= do_end_q ? ST_END : ST_DONE;
                            bit_q <= 4'd0;
                        end else begin
                            bit_q <= bit_q + 4'd1;
                        end
                    end
                endcase
            end
            if (tick && st_q == ST_END) begin
                case (ph_q)
                    2'd0: begin
                        scl_q <= 1'b0;
                        sda_q <= ~end_stop_q;
                    end
                    2'd1: scl_q <= 1'b1;
                    2'd2: sda_q <= end_stop_q;
                    default: begin
                        if (end_stop_q) begin
                            started_q <= 1'b0;
                            st_q <= ST_DONE;
                        end else begin
                            // Repeated start leaves a fresh START with SCL pulled low
                            scl_q <= 1'b0;
                            st_q <= ST_DONE;
                        end
                    end
                endcase
            end
            if (st_q == ST_DONE) begin
                busy_q <= 1'b0;
                txif_q <= 1'b1;
                // Bus stays stretched low until next frame unless stopped
                scl_q <= started_q ? 1'b0 : 1'b1;
                if (!started_q) begin
                    sda_q <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/tws_port_sva.sv
// Purpose: Port-level checks for the two-wire serial port.
// Assumes: Divider bytes are written only while the port is idle.
// Notes: Bound into tws_port at the foot of this file.
`include "tws_defs.vh"
`timescale 1ns/1ns
`default_nettype none
module tws_port_sva #(
    parameter DIV_W = 16
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_B,
    // Register port
    input wire logic [`TWS_ADDR_W-1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    // Wires
    input wire logic SDA_O,
    input wire logic SDA_OE,
    input wire logic SCL_O,
    input wire logic SCL_OE,
    input wire logic PORT_ACTIVE
);
    logic [15:0] th_q;
    logic [19:0] gap_q;
    logic scl_q;
    // Shadow of the divider so clock timing can be judged from outside
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            th_q <= 16'h0000;
            gap_q <= 20'h00000;
            scl_q <= 1'b1;
        end else begin
            if (WR && ADDR == `TWS_A_DIVL) th_q[7:0] <= WDATA;
            if (WR && ADDR == `TWS_A_DIVH) th_q[15:8] <= WDATA;
            gap_q <= (SCL_O && !scl_q) ? 20'h00001 : gap_q + 20'h00001;
            scl_q <= SCL_O;
        end
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);
    sequence s_start; SCL_O && $rose(SDA_OE); endsequence
    sequence s_stop; SCL_O && $fell(SDA_OE); endsequence
    sequence s_idle; SCL_O && !SDA_OE; endsequence
    property p_pin_hand; WR && ADDR == `TWS_A_PCTRL0 |=> PORT_ACTIVE == $past(WDATA[6]); endproperty
    a_pin_hand: assert property (p_pin_hand) else $error("port enable not followed");
    property p_scl_drive; SCL_OE == PORT_ACTIVE; endproperty
    a_scl_drive: assert property (p_scl_drive) else $error("clock pin drive wrong");
    property p_open_drain; !SDA_O && (PORT_ACTIVE || !SDA_OE); endproperty
    a_open_drain: assert property (p_open_drain) else $error("data pin driven high or while off");
    property p_edge_apart; $changed(SCL_O) |-> $stable(SDA_OE); endproperty
    a_edge_apart: assert property (p_edge_apart) else $error("data moved with clock edge");
    property p_start_hold; s_start |-> $past(SCL_O) ##1 SCL_O; endproperty
    a_start_hold: assert property (p_start_hold) else $error("start without clock high");
    property p_stop_idle; s_stop |=> s_idle [*4]; endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("bus not idle after stop");
    property p_rd_quiet; !RD |=> RDATA == 8'h00; endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside read");
    property p_bit_period; SCL_O && !scl_q |-> gap_q >= 4 * (th_q + 1); endproperty
    a_bit_period: assert property (p_bit_period) else $error("clock period too short");
endmodule
bind tws_port tws_port_sva #(.DIV_W(DIV_W)) u_sva (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .SCL_O(SCL_O), .SCL_OE(SCL_OE),
    .PORT_ACTIVE(PORT_ACTIVE));
`default_nettype wire

// File: tb/tws_slave.sv
// Purpose: Behavioural slave on the two wires.
// Assumes: Data wire has a pull-up.
// Notes: Returns pat MSB first, then acknowledges low.
`timescale 1ns/1ns
`default_nettype none
module tws_slave (
    // Wire levels
    input wire logic scl,
    input wire logic sda,
    // Byte returned to the master
    input wire logic [7:0] pat,
    // High pulls the data wire low
    output wire logic pull
);
    // Count of clock falls since the last START; 15 means no frame
    logic [3:0] n = 4'hf;
    logic sda_prev = 1'b1;
    logic scl_prev = 1'b1;
    always @(sda or scl) begin
        if (scl && scl_prev && sda != sda_prev) begin
            n = sda ? 4'hf : 4'h0;
        end else if (!scl && scl_prev && n != 4'hf) begin
            n = n + 4'h1;
        end
        sda_prev = sda;
        scl_prev = scl;
    end
    // Level follows the fall count, so a byte handed over while the clock is stretched is still used
    assign pull = (n >= 4'h1 && n <= 4'h8) ? !pat[3'(4'h8 - n)] : (n == 4'h9);
endmodule
`default_nettype wire

// File: tb/tws_port_tb.sv
// Purpose: Self-checking bench for the two-wire serial port.
// Assumes: Slave model on the wires, pull-up on both.
// Notes: Divider kept at or above 62 so the clock stays in range.
`include "tws_defs.vh"
`timescale 1ns/1ns
`default_nettype none
module tws_port_tb;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic chk_r = 1'b0;
    logic rd_d = 1'b0;
    logic scl_d = 1'b1;
    logic [7:0] pat = 8'hff;
    logic [7:0] th, w, p, v, rv;
    logic [3:0] rises = 4'h0;
    logic [7:0] exp_q[$];
    logic [15:0] regs[7] = '{16'h2d00, 16'h2f01, 16'h2f02, 16'h2f03, 16'h2f04, 16'h2f05, 16'h2f06};
    logic [7:0] bad_cfg[3] = '{8'h00, 8'h05, 8'h0f};
    int bad_count = 0;
    int total_checks = 0;
    wire [7:0] rdata;
    wire irq, sda_o, sda_oe, scl_o, scl_oe, port_active, pull;
    wire sda = !(sda_oe | pull);
    wire scl = scl_oe ? scl_o : 1'b1;
    always #5 sys_clk = ~sys_clk;
    tws_port #(.DIV_W(16)) dut (.SYS_CLK(sys_clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .IRQ(irq), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .SCL_I(scl), .SCL_O(scl_o),
        .SCL_OE(scl_oe), .PORT_ACTIVE(port_active));
    tws_slave u_slave (.scl(scl), .sda(sda), .pat(pat), .pull(pull));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    always @(posedge sys_clk) begin
        if (rd_d) check(rdata, exp_q.pop_front());
        rd_d <= rd & chk_r;
        scl_d <= scl_o;
        if (scl_o && !scl_d) rises <= rises + 4'h1;
    end
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    // Unchecked reads still leave their value in v for polling
    task automatic rd_reg(input logic [15:0] a, input logic [7:0] e, input logic c);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        chk_r <= c;
        if (c) exp_q.push_back(e);
        @(posedge sys_clk);
        rd <= 1'b0;
        @(negedge sys_clk);
        v = rdata;
    endtask
    task automatic frame(input logic [7:0] cfg, input logic [7:0] pw, input logic [7:0] pp, input logic [3:0] nr,
        input logic bw);
        int i;
        logic [3:0] r0;
        wr_reg(`TWS_A_CFG, cfg);
        wr_reg(`TWS_A_FLAGS, 8'h0d);
        pat = pp;
        r0 = rises;
        wr_reg(`TWS_A_DATA, pw);
        if (bw) wr_reg(`TWS_A_CFG, 8'haa);
        i = 0;
        v = 8'h02;
        while (v[1] !== 1'b0 && i < 3000) begin
            rd_reg(`TWS_A_FLAGS, 8'h00, 1'b0);
            i++;
        end
        check({7'h00, v[1]}, 8'h00);
        check({4'h0, 4'(rises - r0)}, {4'h0, nr});
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        th = 8'd62 + 8'($urandom(19445) % 4);
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        // Acknowledge flag comes out of reset high (not acknowledged)
        foreach (regs[i]) rd_reg(regs[i], (i == 5) ? 8'h01 : 8'h00, 1'b1);
        wr_reg(`TWS_A_IRQEN, 8'h30);
        wr_reg(`TWS_A_DIVL, th);
        wr_reg(`TWS_A_DIVH, 8'h00);
        rd_reg(`TWS_A_DIVL, th, 1'b1);
        wr_reg(`TWS_A_PCTRL0, 8'h40);
        rd_reg(`TWS_A_PCTRL0, 8'h40, 1'b1);
        frame(8'h07, 8'hff, 8'hff, 4'h0, 1'b0);
        rd_reg(`TWS_A_FLAGS, 8'h05, 1'b1);
        w = $urandom;
        p = $urandom;
        frame(8'h0b, w, p, 4'h9, 1'b1);
        rd_reg(`TWS_A_DATA, w & p, 1'b1);
        rd_reg(`TWS_A_FLAGS, 8'h0c, 1'b1);
        rd_reg(`TWS_A_CFG, 8'h0b, 1'b1);
        check({7'h00, irq}, 8'h01);
        frame(8'h0e, 8'hff, 8'hff, 4'h1, 1'b0);
        rd_reg(`TWS_A_FLAGS, 8'h05, 1'b1);
        w = $urandom;
        p = $urandom;
        rv = {<<{p}};
        frame(8'h19, w, p, 4'ha, 1'b0);
        rd_reg(`TWS_A_DATA, w & rv, 1'b1);
        rd_reg(`TWS_A_FLAGS, 8'h04, 1'b1);
        check({6'h00, scl_o, sda}, 8'h03);
        w = $urandom;
        p = $urandom;
        frame(8'h03, w, p, 4'h9, 1'b0);
        rd_reg(`TWS_A_DATA, w & p, 1'b1);
        frame(8'h0d, 8'hff, 8'hff, 4'h1, 1'b0);
        check({6'h00, scl_o, sda}, 8'h03);
        foreach (bad_cfg[i]) begin
            frame(bad_cfg[i], 8'hff, 8'hff, 4'h0, 1'b0);
            rd_reg(`TWS_A_FLAGS, 8'h01, 1'b1);
        end
        give_verdict();
    end
    initial begin
        #300000;
        bad_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
